// ### include/iwd_pkg.sv
// Shared constants and types for the instruction word decoder.
// What this block does
// (RULE1) An ordinary instruction is one 16-bit program word.
// (RULE2) Single words split into an opcode and refining operand fields.
// (RULE3) Exactly four instructions span two words, a 32-bit encoding.
// (RULE4) Second words start with four ones; alone they execute as no-op.
// (RULE5) Single words take one cycle; two when a test is true or flow moves.
// (RULE6) Double-word instructions take two instruction cycles.
// (RULE7) One instruction cycle is four oscillator periods.
// (RULE8) A true test over a double-word instruction occupies three cycles.
// (RULE9) Destination bit clear writes the accumulator, set writes the file.
// (RULE10) Byte operations carry file address, destination bit, access bit.
// (RULE11) Bit operations carry file address, bit number and access bit.
// (RULE12) Literal operations carry a constant, a pointer selector or nothing.
// (RULE13) Control operations carry address, call mode, table mode or nothing.
// (RULE14) Recognise the 75-instruction core set plus 8 extended ones.
// (RULE15) Access bit 0 uses the fixed bank; 1 uses the bank selector.
// (RULE16) Fast bit 1 uses shadow registers; 0 leaves them untouched.
// (RULE17) Table operations apply none, post-inc, post-dec or pre-inc.
// (RULE18) Register moves carry full 12-bit source and destination addresses.
// (RULE19) Inserted no-op cycles change no architectural state.
// (RULE20) Fetch gives one word per cycle, flagged first or second.
`default_nettype none
package iwd_pkg;
  localparam int          IWD_PHASES      = 4;
  localparam int          IWD_CLK_NS      = 10;
  localparam int          IWD_CORE_OPS    = 75;
  localparam int          IWD_EXT_OPS     = 8;
  localparam logic [15:0] IWD_RST_WORD    = 16'hF000;
  localparam logic [7:0]  IWD_ACCESS_SPLIT = 8'h60;
  localparam logic [3:0]  IWD_ACC_LO_BANK = 4'h0;
  localparam logic [3:0]  IWD_ACC_HI_BANK = 4'hF;
  localparam logic [3:0]  OP_SECOND       = 4'hF;
  localparam logic [3:0]  OP_MOVE         = 4'hC;
  localparam logic [3:0]  OP_RELJUMP      = 4'hD;
  localparam logic [3:0]  OP_BIT_LO       = 4'h7;
  localparam logic [3:0]  OP_BIT_HI       = 4'hB;
  localparam logic [3:0]  OP_BYTE_HI      = 4'h6;
  localparam logic [7:0]  OP_CTRL0        = 8'h00;
  localparam logic [7:0]  OP_BANKLIT      = 8'h01;
  localparam logic [7:0]  OP_RETLIT       = 8'h0C;
  localparam logic [7:0]  OP_PTRLIT       = 8'hEE;
  localparam logic [7:0]  OP_EXTMOVE      = 8'hEB;
  localparam logic [5:0]  OP_LONG         = 6'h3B;
  localparam logic [6:0]  OP_LONGCALL     = 7'h76;
  localparam logic [5:0]  OP_EXT          = 6'h3A;
  localparam logic [4:0]  OP_LIT8         = 5'h01;
  localparam logic [4:0]  OP_CONDJUMP     = 5'h1C;
  localparam logic [12:0] OP_TABLE        = 13'h0001;
  localparam logic [13:0] OP_RETURN       = 14'h0004;
  localparam logic [15:0] OP_RESTART      = 16'h00FF;
  localparam logic [5:0]  OP_DECSKIP      = 6'h0B;
  localparam logic [5:0]  OP_INCSKIP      = 6'h0F;
  localparam logic [5:0]  OP_INCSKIPNZ    = 6'h12;
  localparam logic [5:0]  OP_DECSKIPNZ    = 6'h13;
  localparam logic [4:0]  OP_CMPSKIP      = 5'h0C;
  localparam logic [2:0]  OP_BITSKIP      = 3'h5;

  typedef enum logic [1:0] {
    ST_EXEC  = 2'h0,
    ST_WORD2 = 2'h1,
    ST_FLUSH = 2'h2
  } iwd_state_t;

  typedef enum logic [2:0] {
    CL_NONE = 3'h0,
    CL_BYTE = 3'h1,
    CL_BIT  = 3'h2,
    CL_LIT  = 3'h3,
    CL_CTRL = 3'h4,
    CL_MOVE = 3'h5
  } iwd_class_t;

  typedef enum logic [1:0] {
    TM_KEEP    = 2'h0,
    TM_POSTINC = 2'h1,
    TM_POSTDEC = 2'h2,
    TM_PREINC  = 2'h3
  } iwd_tblmode_t;
endpackage : iwd_pkg
`default_nettype wire

// ### verilog/iwd_phase_gen.sv
// Oscillator phase counter that frames each instruction cycle.
`default_nettype none
module iwd_phase_gen
  import iwd_pkg::*;
#(
  parameter int PHASES = IWD_PHASES
)
(
  input  wire logic                      clk_i,
  input  wire logic                      srst_i,
  output logic [$clog2(PHASES)-1:0]      phase_o,
  output logic                           last_o
);
  localparam int PW = $clog2(PHASES);

  // (RULE7) Four-period framing.
  assign last_o = (phase_o == PW'(PHASES - 1));

  always_ff @(posedge clk_i)
  begin
    if (srst_i || last_o)
    begin
      phase_o <= '0;
    end
    else
    begin
      phase_o <= phase_o + 1'b1;
    end
  end
endmodule : iwd_phase_gen
`default_nettype wire

// ### verilog/iwd_decoder.sv
// Instruction word decoder and instruction cycle sequencer.
`default_nettype none
module iwd_decoder
  import iwd_pkg::*;
#(
  parameter logic [7:0] ACCESS_SPLIT = IWD_ACCESS_SPLIT
)
(
  input  wire logic         clk_i,
  input  wire logic         srst_i,
  input  wire logic [15:0]  word_i,
  input  wire logic         word_valid_i,
  input  wire logic         second_word_i,
  input  wire logic         cond_true_i,
  input  wire logic         ext_en_i,
  input  wire logic [3:0]   ram_bank_selector_i,
  output logic [1:0]        phase_o,
  output logic              cycle_start_o,
  output logic              nop_o,
  output iwd_class_t        class_o,
  output logic [7:0]        opcode_o,
  output logic              two_word_o,
  output logic              word_idx_o,
  output logic [11:0]       file_addr_o,
  output logic              dest_file_o,
  output logic [2:0]        bit_sel_o,
  output logic [11:0]       literal_o,
  output logic [1:0]        ptr_sel_o,
  output logic              fast_o,
  output logic              tbl_rd_o,
  output logic              tbl_wr_o,
  output iwd_tblmode_t      tbl_mode_o,
  output logic [11:0]       move_src_o,
  output logic [11:0]       move_dst_o,
  output logic [19:0]       prog_addr_o,
  output logic [10:0]       rel_off_o,
  output logic              ext_op_o,
  output logic              write_acc_o,
  output logic              write_file_o,
  output logic              pc_change_o,
  output logic              skip_o
);
  iwd_state_t   st;
  iwd_state_t   next_st;
  logic         skip_fl;
  logic         next_skip;
  logic [15:0]  ir;
  logic [15:0]  next_ir;
  logic [15:0]  w2;
  logic [15:0]  next_w2;
  logic         nop;
  logic         next_nop;
  logic         idx;
  logic         next_idx;
  logic [11:0]  fa;
  logic [11:0]  next_fa;
  logic         last;
  logic         cap;
  logic         in_orph;
  logic         in_known;
  logic         in_dbl;
  logic         in_low;
  logic [11:0]  in_fa;

  // (RULE3) Two-word encodings.
  function automatic logic f_dbl(input logic [15:0] w, input logic ext);
    f_dbl = (w[15:12] == OP_MOVE) || (w[15:10] == OP_LONG) ||
            (ext && (w[15:8] == OP_EXTMOVE));
  endfunction : f_dbl

  iwd_phase_gen #(
    .PHASES (IWD_PHASES)
  ) u_phase (
    .clk_i   (clk_i),
    .srst_i  (srst_i),
    .phase_o (phase_o),
    .last_o  (last)
  );

  // (RULE20) One word taken per cycle.
  assign cycle_start_o = (phase_o == 2'h0);
  assign cap           = cycle_start_o && word_valid_i;

  // (RULE4) Lone second word.
  assign in_orph  = (word_i[15:12] == OP_SECOND) || second_word_i;
  // (RULE14) Extended set gated.
  assign in_known = ext_en_i || (word_i[15:10] != OP_EXT);
  assign in_dbl   = f_dbl(word_i, ext_en_i);

  // (RULE15) Access or selected bank.
  assign in_low = (word_i[7:0] < ACCESS_SPLIT);
  assign in_fa  = word_i[8] ? {ram_bank_selector_i, word_i[7:0]} :
                  in_low    ? {IWD_ACC_LO_BANK, word_i[7:0]} :
                              {IWD_ACC_HI_BANK, word_i[7:0]};

  logic is_ctrl0;
  logic is_banklit;
  logic is_lit8;
  logic is_ptrlit;
  logic is_extop;
  logic is_extlit;
  logic is_byte;
  logic is_bit;
  logic is_move;
  logic is_lit;
  logic is_tbl;
  logic is_ret;
  logic is_call;
  logic is_long;
  logic is_cbr;
  logic is_skip;
  logic uncond;
  logic pc_w;
  logic flush_go;

  // (RULE2) Opcode part selects the class.
  assign is_ctrl0   = (ir[15:8] == OP_CTRL0);
  assign is_banklit = (ir[15:8] == OP_BANKLIT);
  assign is_lit8    = (ir[15:11] == OP_LIT8);
  assign is_ptrlit  = (ir[15:8] == OP_PTRLIT);
  assign is_extop   = ext_en_i && (ir[15:10] == OP_EXT);
  assign is_extlit  = is_extop && (ir[15:8] != OP_EXTMOVE);
  // (RULE10) Byte operand layout.
  assign is_byte = (ir[15:12] <= OP_BYTE_HI) && !is_ctrl0 &&
                   !is_banklit && !is_lit8;
  // (RULE11) Bit operand layout.
  assign is_bit  = (ir[15:12] >= OP_BIT_LO) && (ir[15:12] <= OP_BIT_HI);
  // (RULE18) Full-range moves.
  assign is_move = (ir[15:12] == OP_MOVE) ||
                   (is_extop && (ir[15:8] == OP_EXTMOVE));
  // (RULE12) Literal forms.
  assign is_lit  = is_banklit || is_lit8 || is_ptrlit || is_extlit;

  assign class_o = nop      ? CL_NONE :
                   is_byte  ? CL_BYTE :
                   is_bit   ? CL_BIT  :
                   is_move  ? CL_MOVE :
                   is_lit   ? CL_LIT  :
                              CL_CTRL;

  // (RULE13) Control operand forms.
  assign is_tbl  = (ir[15:3] == OP_TABLE);
  assign is_ret  = (ir[15:2] == OP_RETURN);
  assign is_call = (ir[15:9] == OP_LONGCALL);
  assign is_long = (ir[15:10] == OP_LONG) && !is_ptrlit;
  assign is_cbr  = (ir[15:11] == OP_CONDJUMP);
  // (RULE5) Tests that skip.
  assign is_skip = (ir[15:10] == OP_DECSKIP) ||
                   (ir[15:10] == OP_INCSKIP) ||
                   (ir[15:10] == OP_INCSKIPNZ) ||
                   (ir[15:10] == OP_DECSKIPNZ) ||
                   (ir[15:11] == OP_CMPSKIP) ||
                   (ir[15:13] == OP_BITSKIP);
  assign uncond  = (ir[15:12] == OP_RELJUMP) || is_ret ||
                   (ir[15:8] == OP_RETLIT) || (ir == OP_RESTART);

  assign opcode_o    = ir[15:8];
  assign two_word_o  = f_dbl(ir, ext_en_i);
  assign word_idx_o  = idx;
  assign nop_o       = nop;
  assign file_addr_o = fa;
  assign bit_sel_o   = ir[11:9];
  assign move_src_o  = ir[11:0];
  assign move_dst_o  = w2[11:0];
  assign prog_addr_o = {w2[11:0], ir[7:0]};
  assign rel_off_o   = (ir[15:12] == OP_RELJUMP) ? ir[10:0] :
                       {{3{ir[7]}}, ir[7:0]};
  assign ext_op_o    = is_extop && !nop;
  assign literal_o   = is_ptrlit ? {ir[3:0], w2[7:0]} :
                       is_extlit ? {6'h00, ir[5:0]} :
                                   {4'h0, ir[7:0]};
  assign ptr_sel_o   = is_ptrlit ? ir[5:4] : ir[7:6];
  // (RULE16) Shadow use on fast bit.
  assign fast_o      = !nop && ((is_ret && ir[0]) || (is_call && ir[8]));
  // (RULE17) Table pointer modes.
  assign tbl_rd_o    = !nop && is_tbl && !ir[2];
  assign tbl_wr_o    = !nop && is_tbl && ir[2];
  assign tbl_mode_o  = iwd_tblmode_t'(ir[1:0]);

  // (RULE9) Destination routing.
  assign dest_file_o  = ir[9];
  assign write_acc_o  = last && !nop && is_byte && !ir[9];
  assign write_file_o = last && !nop && is_byte && ir[9];

  // (RULE5) Flow changes end the cycle.
  assign pc_w        = uncond || (is_cbr && cond_true_i);
  assign pc_change_o = last && !nop && (pc_w || (is_long && idx));
  assign skip_o      = last && !nop && is_skip && cond_true_i;
  // (RULE6) Long jumps need no extra cycle.
  assign flush_go    = (last && !nop && pc_w) || skip_o;

  always_comb
  begin
    next_st   = st;
    next_skip = skip_fl;
    next_ir   = ir;
    next_w2   = w2;
    next_nop  = nop;
    next_idx  = idx;
    next_fa   = fa;
    if (cap)
    begin
      case (st)
        ST_EXEC:
        begin
          next_idx = 1'b0;
          if (in_orph || !in_known)
          begin
            next_nop = 1'b1;
          end
          else
          begin
            next_nop = 1'b0;
            // (RULE1) Whole word latched.
            next_ir  = word_i;
            next_fa  = in_fa;
            if (in_dbl)
            begin
              next_st = ST_WORD2;
            end
          end
        end
        ST_WORD2:
        begin
          next_nop = 1'b0;
          next_idx = 1'b1;
          next_w2  = word_i;
          next_st  = ST_EXEC;
        end
        ST_FLUSH:
        begin
          // (RULE8) Skipped pair takes two slots.
          next_nop  = 1'b1;
          next_skip = 1'b0;
          if (!(skip_fl && in_dbl))
          begin
            next_st = ST_EXEC;
          end
        end
        default:
        begin
          next_st = ST_EXEC;
        end
      endcase
    end
    else if (cycle_start_o)
    begin
      next_nop = 1'b1;
    end
    // (RULE19) Flush cycles run as no-ops.
    if (flush_go)
    begin
      next_st   = ST_FLUSH;
      next_skip = skip_o;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (srst_i)
    begin
      st      <= ST_EXEC;
      skip_fl <= 1'b0;
      ir      <= IWD_RST_WORD;
      w2      <= IWD_RST_WORD;
      nop     <= 1'b1;
      idx     <= 1'b0;
      fa      <= '0;
    end
    else
    begin
      st      <= next_st;
      skip_fl <= next_skip;
      ir      <= next_ir;
      w2      <= next_w2;
      nop     <= next_nop;
      idx     <= next_idx;
      fa      <= next_fa;
    end
  end

  // Checks below see only what this block drives or samples.
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (srst_i);

  a_phase_wrap: // (RULE7)
  assert property ((phase_o == 2'h3) |=> (phase_o == 2'h0))
    else $error("Phase did not wrap after four periods.");

  a_cycle_four: // (RULE7)
  assert property (cycle_start_o |=> !cycle_start_o [*3] ##1 cycle_start_o)
    else $error("Instruction cycle is not four periods long.");

  a_word2_follows: // (RULE3)
  assert property ((cap && st == ST_EXEC && !in_orph && in_known && in_dbl)
    |-> ##1 (two_word_o && !word_idx_o && !nop_o)
    ##4 (st == ST_WORD2 || word_idx_o))
    else $error("Second word of a double-word instruction was lost.");

  a_orphan_nop: // (RULE4)
  assert property ((cap && st == ST_EXEC && in_orph) |=> nop_o)
    else $error("Lone second word did not execute as a no-op.");

  a_nop_quiet: // (RULE19)
  assert property (nop_o |->
    !(write_acc_o || write_file_o || pc_change_o || skip_o || fast_o))
    else $error("No-op cycle changed state.");

  a_dest_route: // (RULE9)
  assert property ((write_acc_o || write_file_o) |->
    (write_file_o == dest_file_o) && (class_o == CL_BYTE))
    else $error("Byte result routed to the wrong destination.");

  a_bank_sel: // (RULE15)
  assert property ((cap && st == ST_EXEC && !in_orph && in_known &&
    word_i[8]) |=> (file_addr_o[11:8] == $past(ram_bank_selector_i)))
    else $error("Bank selector not applied with access bit set.");

  a_access_bank: // (RULE15)
  assert property ((cap && st == ST_EXEC && !in_orph && in_known &&
    !word_i[8] && in_low) |=> (file_addr_o[11:8] == IWD_ACC_LO_BANK))
    else $error("Access bank not used with access bit clear.");

  a_flush_after_pc: // (RULE5)
  assert property (((pc_change_o && !two_word_o) || skip_o)
    |-> ##2 nop_o)
    else $error("No no-op cycle after a flow change.");

  a_long_two: // (RULE6)
  assert property ((pc_change_o && two_word_o) |=> (st == ST_EXEC))
    else $error("Double-word jump took an extra cycle.");

  c_double_word: cover property (word_idx_o && !nop_o && two_word_o);
  c_skip_over_dbl: cover property (st == ST_FLUSH && skip_fl && cap &&
    in_dbl);
  c_byte_write: cover property (write_file_o);
  c_cond_jump: cover property (pc_change_o && is_cbr);
endmodule : iwd_decoder
`default_nettype wire

// ### verif/iwd_fetch_model.sv
// Fetch path model that hands the decoder one program word per cycle.
`default_nettype none
module iwd_fetch_model
(
  input  wire logic   clk_i,
  input  wire logic   cycle_start_i,
  output logic [15:0] word_o,
  output logic        word_valid_o,
  output logic        second_word_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [16:0] fifo [$];
  logic [16:0] ent;
  logic [15:0] shown = 16'h0000;

  task automatic push(input logic [15:0] w, input logic sec);
    fifo.push_back({sec, w});
  endtask : push

  always @(negedge clk_i)
  begin
    if (cycle_start_i && fifo.size() > 0)
    begin
      ent = fifo.pop_front();
      shown = ent[15:0];
      word_valid_o <= 1'b1;
      second_word_o <= ent[16];
    end
    else
    begin
      // An idle bus shows the inverse so that stale data never looks fresh.
      shown = ~shown;
      word_valid_o <= 1'b0;
      second_word_o <= 1'b0;
    end
    word_o <= shown;
  end
endmodule : iwd_fetch_model
`default_nettype wire

// ### verif/tb.sv
// Self-checking bench for the instruction word decoder.
`default_nettype none
module tb
  import iwd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic         clk_i, srst_i, word_valid_i, second_word_i, cond_true_i;
  logic         ext_en_i, cycle_start_o, nop_o, two_word_o, word_idx_o;
  logic         dest_file_o, fast_o, tbl_rd_o, tbl_wr_o, ext_op_o;
  logic         write_acc_o, write_file_o, pc_change_o, skip_o;
  logic [1:0]   phase_o, ptr_sel_o;
  logic [2:0]   bit_sel_o;
  logic [3:0]   ram_bank_selector_i;
  logic [7:0]   opcode_o;
  logic [10:0]  rel_off_o;
  logic [11:0]  file_addr_o, literal_o, move_src_o, move_dst_o;
  logic [15:0]  word_i, w;
  logic [19:0]  prog_addr_o;
  iwd_class_t   class_o;
  iwd_tblmode_t tbl_mode_o;
  int           error_cnt, total_checks;

  iwd_decoder u_iwd_decoder (.*);

  iwd_fetch_model u_iwd_fetch_model (
    .clk_i(clk_i), .cycle_start_i(cycle_start_o), .word_o(word_i),
    .word_valid_o(word_valid_i), .second_word_o(second_word_i)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : chk

  task automatic wait_ph(input logic [1:0] ph);
    int n;
    n = 0;
    while (phase_o !== ph)
    begin
      @(negedge clk_i);
      n++;
      if (n > 8)
      begin
        error_cnt++;
        conclude();
      end
    end
  endtask : wait_ph

  // One instruction cycle; returns in phase 3 with the pulses settled.
  task automatic step(input logic [15:0] v, input logic sec, input logic c);
    wait_ph(2'h3);
    u_iwd_fetch_model.push(v, sec);
    wait_ph(2'h2);
    cond_true_i = c;
    wait_ph(2'h3);
  endtask : step

  function automatic logic [11:0] fa(logic [15:0] v, logic [3:0] b);
    if (v[8])
      return {b, v[7:0]};
    return {(v[7:0] < IWD_ACCESS_SPLIT) ? IWD_ACC_LO_BANK : IWD_ACC_HI_BANK,
            v[7:0]};
  endfunction : fa

  // Bit 11 clear keeps clear of the skip encodings in this range.
  function automatic logic [15:0] rbyte();
    logic [15:0] r;
    r = 16'($urandom);
    r[15:12] = 4'h1 + 4'($urandom % 5);
    r[11] = 1'b0;
    return r;
  endfunction : rbyte

  initial
  begin
    error_cnt = 0;
    total_checks = 0;
    srst_i = 1'b1;
    cond_true_i = 1'b0;
    ext_en_i = 1'b0;
    ram_bank_selector_i = 4'h0;
    void'($urandom(76796));
    repeat (5) @(negedge clk_i);
    chk(nop_o, 1'b1);
    chk(class_o, CL_NONE);
    srst_i = 1'b0;
    repeat (4) @(negedge clk_i);
    chk({phase_o, cycle_start_o}, 3'b001);
    $display("test reset done");
    for (int i = 0; i < 40; i++)
    begin
      ram_bank_selector_i = 4'($urandom);
      w = rbyte();
      if (i[0])
      begin
        w[15:12] = 4'h7 + 4'($urandom % 3);
        w[11] = 1'($urandom);
      end
      step(w, 1'b0, 1'($urandom));
      chk({nop_o, skip_o}, 2'b00);
      chk(file_addr_o, fa(w, ram_bank_selector_i));
      chk(opcode_o, w[15:8]);
      if (i[0])
        chk({class_o, bit_sel_o}, {CL_BIT, w[11:9]});
      else
      begin
        chk(class_o, CL_BYTE);
        chk(dest_file_o, w[9]);
        chk({write_file_o, write_acc_o}, {w[9], ~w[9]});
      end
    end
    $display("test byte and bit done");
    for (int b = 8; b < 16; b++)
    begin
      if (b == 12)
        continue;
      w = {8'(b), 8'($urandom)};
      step(w, 1'b0, 1'b0);
      chk({class_o, literal_o}, {CL_LIT, 4'h0, w[7:0]});
    end
    w = {8'h01, 8'($urandom)};
    step(w, 1'b0, 1'b0);
    chk({class_o, literal_o}, {CL_LIT, 4'h0, w[7:0]});
    for (int p = 0; p < 4; p++)
    begin
      w = {8'hEE, 2'h0, 2'(p), 4'($urandom)};
      step(w, 1'b0, 1'b0);
      chk({two_word_o, word_idx_o, nop_o}, 3'b100);
      step({8'hF0, 8'h5A}, 1'b1, 1'b0);
      chk({word_idx_o, nop_o}, 2'b10);
      chk({ptr_sel_o, literal_o}, {2'(p), w[3:0], 8'h5A});
    end
    $display("test literal done");
    for (int t = 8; t < 16; t++)
    begin
      step(16'(t), 1'b0, 1'b0);
      chk(class_o, CL_CTRL);
      chk({tbl_wr_o, tbl_rd_o, tbl_mode_o}, {t[2], ~t[2], t[1:0]});
    end
    for (int j = 0; j < 3; j++)
    begin
      w = {(j == 2) ? 8'hEF : 8'hEC + 8'(j), 8'($urandom)};
      step(w, 1'b0, 1'b0);
      chk(two_word_o, 1'b1);
      step({4'hF, 12'hA5C}, 1'b1, 1'b0);
      chk({pc_change_o, fast_o}, {1'b1, j == 1});
      chk(prog_addr_o, {12'hA5C, w[7:0]});
      step(rbyte(), 1'b0, 1'b0);
      chk(nop_o, 1'b0);
    end
    for (int s = 0; s < 2; s++)
    begin
      step(16'h0012 + 16'(s), 1'b0, 1'b0);
      chk({pc_change_o, fast_o}, {1'b1, s[0]});
      step(rbyte(), 1'b0, 1'b0);
      chk({nop_o, write_acc_o, write_file_o}, 3'b100);
    end
    $display("test control done");
    w = 16'($urandom);
    step({4'hC, w[11:0]}, 1'b0, 1'b0);
    step({4'hF, ~w[11:0]}, 1'b1, 1'b0);
    chk(class_o, CL_MOVE);
    chk({move_src_o, move_dst_o}, {w[11:0], ~w[11:0]});
    for (int s = 0; s < 2; s++)
    begin
      step({4'hF, 12'($urandom)}, s[0], 1'b1);
      chk({nop_o, pc_change_o, skip_o, write_acc_o, write_file_o},
          5'h10);
    end
    $display("test move and lone word done");
    for (int c = 0; c < 2; c++)
    begin
      step({6'h0B, 2'h1, 8'h20}, 1'b0, c[0]);
      chk(skip_o, c[0]);
      step({8'hEF, 8'h00}, 1'b0, 1'b0);
      chk(nop_o, c[0]);
      step({4'hF, 12'h000}, 1'b1, 1'b0);
      chk(nop_o, c[0]);
    end
    step({4'hB, 4'h1, 8'h30}, 1'b0, 1'b1);
    chk(skip_o, 1'b1);
    step(rbyte(), 1'b0, 1'b0);
    chk({nop_o, write_acc_o, write_file_o}, 3'b100);
    for (int c = 0; c < 2; c++)
    begin
      w = {5'h1C, 3'($urandom), 8'($urandom)};
      step(w, 1'b0, c[0]);
      chk({pc_change_o, rel_off_o}, {c[0], {3{w[7]}}, w[7:0]});
      step(rbyte(), 1'b0, 1'b0);
      chk(nop_o, c[0]);
    end
    w = 16'($urandom);
    step({4'hD, w[11:0]}, 1'b0, 1'b0);
    chk({pc_change_o, rel_off_o}, {1'b1, w[10:0]});
    step(rbyte(), 1'b0, 1'b0);
    chk(nop_o, 1'b1);
    $display("test skip and branch done");
    for (int e = 0; e < 2; e++)
    begin
      ext_en_i = e[0];
      step({8'hE8, 8'h12}, 1'b0, 1'b0);
      chk({ext_op_o, nop_o}, {e[0], ~e[0]});
    end
    step({8'hEB, 8'h3C}, 1'b0, 1'b0);
    chk({class_o, two_word_o}, {CL_MOVE, 1'b1});
    step({4'hF, 12'h123}, 1'b1, 1'b0);
    chk({word_idx_o, move_dst_o}, {1'b1, 12'h123});
    ext_en_i = 1'b0;
    $display("test extended done");
    conclude();
  end
endmodule : tb
`default_nettype wire
